// [hw/mcd_clk_sel.sv]
// two-way clock select on sampled clock levels
module mcd_clk_sel (
   input logic clk,
   input logic reset_n,
   input logic src_a,
   input logic src_b,
   input logic sel,
   output logic out_clk,
   output logic cur_sel
);

   logic cur_sel_r;
   logic out_r;
   logic out_nxt;
   logic pending;
   logic src_cur;
   logic src_new;
   logic swap_ok;

   // a change waits until the old phase has ended and the new source is low
   assign pending = sel != cur_sel_r;
   assign src_cur = cur_sel_r ? src_b : src_a;
   assign src_new = sel ? src_b : src_a;
   assign swap_ok = pending & ~out_r & ~src_new;
   // a high phase in flight is finished, never cut short
   assign out_nxt = pending ? (out_r & src_cur) : src_cur;

   // state of the selector
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cur_sel_r <= 1'b0;
         out_r <= 1'b0;
      end else begin
         if (swap_ok) begin
            cur_sel_r <= sel;
         end
         out_r <= out_nxt;
      end
   end

   assign out_clk = out_r;
   assign cur_sel = cur_sel_r;

   property p_low_while_pending;
      @(posedge clk) disable iff (!reset_n) (pending && !out_r) |=> !out_r;
   endproperty
   a_low_while_pending: assert property (p_low_while_pending)
      else $error("clock rose while a source change was pending");

   property p_swap_at_low;
      @(posedge clk) disable iff (!reset_n) $changed(cur_sel_r) |-> (!$past(out_r) && !out_r);
   endproperty
   a_swap_at_low: assert property (p_swap_at_low)
      else $error("source changed while output clock was high");

endmodule // mcd_clk_sel

// [hw/mcd_pkg.sv]
package mcd_pkg;

   // system clock rate, used to turn times into cycle counts
   localparam int CLK_MHZ = 125;

   // internal oscillator accuracy settling time, rounded up to whole cycles
   localparam int INT_HS_STAB_NS = 2000;
   localparam int INT_HS_STAB_CYC = (INT_HS_STAB_NS * CLK_MHZ + 999) / 1000;
   localparam int INT_HS_CNT_W = 12;

   // crystal settling counter: edges of the crystal clock, five tap points
   localparam int OST_CNT_W = 19;
   localparam int OST_N = 5;
   localparam int OST_EXP [0:4] = '{8, 11, 13, 15, 18};
   localparam logic [2:0] OST_SEL_MAX = 3'h4;

   // cpu divider: code n divides by 2**n, codes above 4 are refused
   localparam logic [2:0] DIV_SEL_RST = 3'h1;
   localparam logic [2:0] DIV_SEL_MAX = 3'h4;
   localparam int DIV_CNT_W = 3;

   // use of the two high-speed pins
   typedef enum logic [2:0] {
      MCD_PIN_PORT = 3'h1,
      MCD_PIN_OSC = 3'h2,
      MCD_PIN_EXT = 3'h4
   } mcd_pin_mode_t;

   // standby sequencing
   typedef enum logic [2:0] {
      MCD_RUN = 3'h1,
      MCD_STOP = 3'h2,
      MCD_WAIT = 3'h4
   } mcd_stop_st_t;

endpackage

// [hw/mcd_top.sv]
// Function
// - after reset both high-speed pins are input ports, no oscillator or clock input.
// - external select 0 with pin select 1 puts pins into crystal oscillation mode.
// - both selects 1 give external clock mode; first pin stays port.
// - in oscillation mode, stop bit 0 runs the crystal oscillator.
// - in external mode, stop bit 0 enables the external clock input.
// - stop bit 1 stops the crystal or disables the external clock input.
// - select pair 0x gives internal to both; 10 splits; 11 gives high-speed to both.
// - high-speed main clock always implies high-speed peripheral clock.
// - cpu source select 0 feeds the cpu from the divided main clock.
// - divider codes 0 to 4 divide by 1 to 16, default by 2; others refused.
// - after reset the internal oscillator runs and clocks the cpu.
// - internal stop bit 0 restarts the internal oscillator.
// - stable flag rises once the internal oscillator has settled.
// - stop instruction enters stop mode and halts the high-speed system clock.
// - stop mode also halts the internal oscillator.
// - status shows cpu source: high-speed, internal or subsystem clock.
// - internal stop bit 1 stops the internal oscillator outside stop mode.
// - a readable crystal settling count status is provided.
module mcd_top #(
   parameter int OST_EXP [0:4] = mcd_pkg::OST_EXP
) (
   input logic clk,
   input logic reset_n,
   input logic ext_clk_sel,
   input logic hs_pin_osc_sel,
   input logic hs_clk_stop,
   input logic main_src_sel,
   input logic periph_src_sel,
   input logic cpu_src_sel,
   input logic [2:0] cpu_div_sel,
   input logic int_hs_stop,
   input logic [2:0] osc_stab_sel,
   input logic stop_exec,
   input logic wake_req,
   input logic xtal_clk_i,
   input logic ext_clk_pin_i,
   input logic int_hs_clk_i,
   input logic sub_clk_i,
   output logic crystal_in_pin_port,
   output logic crystal_out_pin_port,
   output logic xtal_osc_en,
   output logic ext_clk_in_en,
   output logic int_hs_osc_en,
   output logic int_hs_stable,
   output logic main_hs_active,
   output logic sub_clk_active,
   output logic [4:0] osc_stab_count_status,
   output logic stop_mode,
   output logic cpu_clk_out,
   output logic periph_clk_out
);

   localparam logic [11:0] IHS_CYC = 12'(mcd_pkg::INT_HS_STAB_CYC);
   localparam int OW = mcd_pkg::OST_CNT_W;

   // pin clocks come from outside, each passes two flops first
   logic [3:0] async_in;
   logic [3:0] sync1_r;
   logic [3:0] sync2_r;
   assign async_in = {sub_clk_i, int_hs_clk_i, ext_clk_pin_i, xtal_clk_i};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               sync1_r[gi] <= 1'b0;
               sync2_r[gi] <= 1'b0;
            end else begin
               sync1_r[gi] <= async_in[gi];
               sync2_r[gi] <= sync1_r[gi];
            end
         end
      end
   endgenerate

   mcd_pkg::mcd_pin_mode_t mode_w;
   mcd_pkg::mcd_pin_mode_t mode_r;
   mcd_pkg::mcd_stop_st_t st_r;
   mcd_pkg::mcd_stop_st_t st_nxt;
   logic x1_port_r;
   logic x2_port_r;
   logic xtal_en_r;
   logic ext_en_r;
   logic int_en_r;
   logic halt_w;
   logic xtal_en_nxt;
   logic ext_en_nxt;
   logic int_en_nxt;

   // pin use follows the two select bits
   assign mode_w = !hs_pin_osc_sel ? mcd_pkg::MCD_PIN_PORT :
      (ext_clk_sel ? mcd_pkg::MCD_PIN_EXT : mcd_pkg::MCD_PIN_OSC);

   // sources are enabled from the registered mode; stop mode overrides all
   assign halt_w = st_nxt == mcd_pkg::MCD_STOP;
   assign xtal_en_nxt = (mode_r == mcd_pkg::MCD_PIN_OSC) & ~hs_clk_stop & ~halt_w;
   assign ext_en_nxt = (mode_r == mcd_pkg::MCD_PIN_EXT) & ~hs_clk_stop & ~halt_w;
   assign int_en_nxt = ~int_hs_stop & ~halt_w;

   // pin mode and oscillator enables; internal oscillator starts by itself
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         mode_r <= mcd_pkg::MCD_PIN_PORT;
         x1_port_r <= 1'b1;
         x2_port_r <= 1'b1;
         xtal_en_r <= 1'b0;
         ext_en_r <= 1'b0;
         int_en_r <= 1'b1;
      end else begin
         mode_r <= mode_w;
         x1_port_r <= mode_w != mcd_pkg::MCD_PIN_OSC;
         x2_port_r <= mode_w == mcd_pkg::MCD_PIN_PORT;
         xtal_en_r <= xtal_en_nxt;
         ext_en_r <= ext_en_nxt;
         int_en_r <= int_en_nxt;
      end
   end

   // source levels, gated by their enables except the subsystem clock
   logic hs_lvl;
   logic xtal_lvl;
   logic int_lvl;
   logic sub_lvl;
   assign xtal_lvl = xtal_en_r & sync2_r[0];
   assign hs_lvl = xtal_lvl | (ext_en_r & sync2_r[1]);
   assign int_lvl = int_en_r & sync2_r[2];
   assign sub_lvl = sync2_r[3];

   // main and peripheral selection, interlocked so main never leads peripheral
   logic main_hs_cur;
   logic periph_hs_cur;
   logic main_sel_w;
   logic periph_sel_w;
   logic main_lvl;
   logic periph_lvl;
   assign periph_sel_w = main_src_sel | main_hs_cur;
   assign main_sel_w = main_src_sel & periph_src_sel & periph_hs_cur;

   mcd_clk_sel u_periph_sel (
      .clk(clk),
      .reset_n(reset_n),
      .src_a(int_lvl),
      .src_b(hs_lvl),
      .sel(periph_sel_w),
      .out_clk(periph_lvl),
      .cur_sel(periph_hs_cur)
   );

   mcd_clk_sel u_main_sel (
      .clk(clk),
      .reset_n(reset_n),
      .src_a(int_lvl),
      .src_b(hs_lvl),
      .sel(main_sel_w),
      .out_clk(main_lvl),
      .cur_sel(main_hs_cur)
   );

   // cpu divider on the main clock; a new ratio loads only at a low boundary
   logic main_d_r;
   logic [2:0] div_cur_r;
   logic [mcd_pkg::DIV_CNT_W-1:0] cnt_r;
   logic [mcd_pkg::DIV_CNT_W-1:0] cnt_nxt;
   logic [mcd_pkg::DIV_CNT_W-1:0] half_w;
   logic div_out_r;
   logic div_out_nxt;
   logic main_rise;
   logic div_ok;
   logic div_load;
   logic wrap_w;
   assign main_rise = main_lvl & ~main_d_r;
   assign half_w = 3'(((5'h01 << div_cur_r) - 5'h01) >> 1);
   assign wrap_w = cnt_r == half_w;
   assign div_ok = cpu_div_sel <= mcd_pkg::DIV_SEL_MAX;
   assign div_load = div_ok & (cpu_div_sel != div_cur_r) & ~div_out_r & ~main_lvl
      & (cnt_r == '0);

   // next divider output and count
   always_comb begin
      div_out_nxt = div_out_r;
      cnt_nxt = cnt_r;
      if (div_load) begin
         div_out_nxt = 1'b0;
         cnt_nxt = '0;
      end else if (div_cur_r == 3'h0) begin
         div_out_nxt = main_lvl;
         cnt_nxt = '0;
      end else if (main_rise) begin
         if (wrap_w) begin
            div_out_nxt = ~div_out_r;
            cnt_nxt = '0;
         end else begin
            cnt_nxt = cnt_r + 3'h1;
         end
      end
   end

   // divider registers, default ratio two
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         main_d_r <= 1'b0;
         div_cur_r <= mcd_pkg::DIV_SEL_RST;
         cnt_r <= '0;
         div_out_r <= 1'b0;
      end else begin
         main_d_r <= main_lvl;
         if (div_load) begin
            div_cur_r <= cpu_div_sel;
         end
         cnt_r <= cnt_nxt;
         div_out_r <= div_out_nxt;
      end
   end

   // cpu source: divided main clock or subsystem clock
   logic cpu_mux_lvl;
   logic cpu_sub_cur;
   mcd_clk_sel u_cpu_sel (
      .clk(clk),
      .reset_n(reset_n),
      .src_a(div_out_r),
      .src_b(sub_lvl),
      .sel(cpu_src_sel),
      .out_clk(cpu_mux_lvl),
      .cur_sel(cpu_sub_cur)
   );

   // internal oscillator settling count; restarts whenever it is stopped
   logic [11:0] ihs_cnt_r;
   logic ihs_done_w;
   logic stable_r;
   assign ihs_done_w = ihs_cnt_r == IHS_CYC;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ihs_cnt_r <= '0;
         stable_r <= 1'b0;
      end else begin
         if (!int_en_r) begin
            ihs_cnt_r <= '0;
         end else if (!ihs_done_w) begin
            ihs_cnt_r <= ihs_cnt_r + 12'h001;
         end
         stable_r <= int_en_r & ihs_done_w;
      end
   end

   // crystal settling counter, saturating; cleared while the crystal is off
   logic xtal_d_r;
   logic [OW-1:0] ost_cnt_r;
   logic [4:0] ost_stat_w;
   logic [4:0] ost_stat_r;
   logic [2:0] ost_idx_w;
   logic ost_done_w;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         xtal_d_r <= 1'b0;
         ost_cnt_r <= '0;
         ost_stat_r <= 5'h00;
      end else begin
         xtal_d_r <= xtal_lvl;
         if (!xtal_en_r) begin
            ost_cnt_r <= '0;
         end else if (xtal_lvl && !xtal_d_r && ost_cnt_r != '1) begin
            ost_cnt_r <= ost_cnt_r + {{(OW-1){1'b0}}, 1'b1};
         end
         // stale taps would claim a settled crystal that has been stopped
         ost_stat_r <= xtal_en_r ? ost_stat_w : 5'h00;
      end
   end

   generate
      for (gi = 0; gi < mcd_pkg::OST_N; gi++) begin : g_ost
         assign ost_stat_w[gi] = ost_cnt_r >= ({{(OW-1){1'b0}}, 1'b1} << OST_EXP[gi]);
      end
   endgenerate

   // out-of-range wait codes fall back to the longest wait
   assign ost_idx_w = (osc_stab_sel > mcd_pkg::OST_SEL_MAX) ? mcd_pkg::OST_SEL_MAX : osc_stab_sel;
   assign ost_done_w = ost_stat_w[ost_idx_w];

   // stop sequencing; waking on a crystal-fed cpu waits for the chosen settle
   logic need_wait_w;
   assign need_wait_w = main_hs_active & ~sub_clk_active & (mode_r == mcd_pkg::MCD_PIN_OSC);
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         mcd_pkg::MCD_RUN: begin
            if (stop_exec) st_nxt = mcd_pkg::MCD_STOP;
         end
         mcd_pkg::MCD_STOP: begin
            if (wake_req) st_nxt = need_wait_w ? mcd_pkg::MCD_WAIT : mcd_pkg::MCD_RUN;
         end
         mcd_pkg::MCD_WAIT: begin
            if (ost_done_w) st_nxt = mcd_pkg::MCD_RUN;
         end
         default: st_nxt = mcd_pkg::MCD_RUN;
      endcase
   end

   // cpu clock gate only moves while the selected clock is low
   logic cpu_run_r;
   logic cpu_clk_r;
   logic main_hs_r;
   logic sub_act_r;
   logic periph_clk_r;
   logic stop_mode_r;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_r <= mcd_pkg::MCD_RUN;
         cpu_run_r <= 1'b1;
         cpu_clk_r <= 1'b0;
         periph_clk_r <= 1'b0;
         main_hs_r <= 1'b0;
         sub_act_r <= 1'b0;
         stop_mode_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         if (!cpu_mux_lvl) begin
            cpu_run_r <= st_r == mcd_pkg::MCD_RUN;
         end
         cpu_clk_r <= cpu_mux_lvl & cpu_run_r;
         periph_clk_r <= periph_lvl;
         main_hs_r <= main_hs_cur;
         sub_act_r <= cpu_sub_cur;
         stop_mode_r <= st_nxt != mcd_pkg::MCD_RUN;
      end
   end

   assign crystal_in_pin_port = x1_port_r;
   assign crystal_out_pin_port = x2_port_r;
   assign xtal_osc_en = xtal_en_r;
   assign ext_clk_in_en = ext_en_r;
   assign int_hs_osc_en = int_en_r;
   assign int_hs_stable = stable_r;
   assign main_hs_active = main_hs_r;
   assign sub_clk_active = sub_act_r;
   assign osc_stab_count_status = ost_stat_r;
   assign stop_mode = stop_mode_r;
   assign cpu_clk_out = cpu_clk_r;
   assign periph_clk_out = periph_clk_r;

   property p_reset_state;
      @(posedge clk) $past(!reset_n) && reset_n |-> (x1_port_r && x2_port_r && !xtal_en_r
         && !ext_en_r && int_en_r && !main_hs_r && !sub_act_r);
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("wrong clock state after reset");

   property p_osc_mode;
      @(posedge clk) disable iff (!reset_n) (hs_pin_osc_sel && !ext_clk_sel)
         |=> (!x1_port_r && !x2_port_r && mode_r == mcd_pkg::MCD_PIN_OSC);
   endproperty
   a_osc_mode: assert property (p_osc_mode)
      else $error("pins did not enter oscillation mode");

   property p_ext_mode;
      @(posedge clk) disable iff (!reset_n) (hs_pin_osc_sel && ext_clk_sel)
         |=> (x1_port_r && !x2_port_r);
   endproperty
   a_ext_mode: assert property (p_ext_mode)
      else $error("external clock mode pins wrong");

   property p_xtal_run;
      @(posedge clk) disable iff (!reset_n) (mode_r == mcd_pkg::MCD_PIN_OSC && !hs_clk_stop
         && st_r == mcd_pkg::MCD_RUN && !stop_exec) |=> xtal_en_r && !ext_en_r;
   endproperty
   a_xtal_run: assert property (p_xtal_run)
      else $error("crystal oscillator not started");

   property p_ext_run;
      @(posedge clk) disable iff (!reset_n) (mode_r == mcd_pkg::MCD_PIN_EXT && !hs_clk_stop
         && st_r == mcd_pkg::MCD_RUN && !stop_exec) |=> ext_en_r && !xtal_en_r;
   endproperty
   a_ext_run: assert property (p_ext_run)
      else $error("external clock input not enabled");

   property p_hs_stop;
      @(posedge clk) disable iff (!reset_n) hs_clk_stop |=> !xtal_en_r && !ext_en_r;
   endproperty
   a_hs_stop: assert property (p_hs_stop)
      else $error("high-speed clock still enabled after stop bit");

   property p_periph_follows;
      @(posedge clk) disable iff (!reset_n) main_hs_cur |-> periph_hs_cur;
   endproperty
   a_periph_follows: assert property (p_periph_follows)
      else $error("main clock high-speed while peripheral clock is not");

   property p_stop_halts;
      @(posedge clk) disable iff (!reset_n) (stop_exec && st_r == mcd_pkg::MCD_RUN)
         |=> (!xtal_en_r && !ext_en_r && !int_en_r && stop_mode) [*2];
   endproperty
   a_stop_halts: assert property (p_stop_halts)
      else $error("stop mode left an oscillator running");

   property p_int_stop;
      @(posedge clk) disable iff (!reset_n) int_hs_stop |=> !int_en_r ##1 !stable_r;
   endproperty
   a_int_stop: assert property (p_int_stop)
      else $error("internal oscillator not stopped");

   property p_stable_wait;
      @(posedge clk) disable iff (!reset_n) $rose(stable_r) |-> $past(int_en_r, 1)
         && $past(ihs_cnt_r, 1) == IHS_CYC;
   endproperty
   a_stable_wait: assert property (p_stable_wait)
      else $error("stable flag rose before settling time");

   property p_ost_status;
      @(posedge clk) disable iff (!reset_n) ost_stat_r[0] |-> $past(xtal_en_r);
   endproperty
   a_ost_status: assert property (p_ost_status)
      else $error("settling status set with crystal off");

endmodule // mcd_top

// [sim/test_mcd_top.sv]
module test_mcd_top;
   timeunit 1ns;
   timeprecision 100ps;

   // short settling taps so the crystal wait stays around 128 cycles
   localparam int TAPS [0:4] = '{1, 2, 3, 4, 5};

   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic ext_clk_sel = 1'b0;
   logic hs_pin_osc_sel = 1'b0;
   logic hs_clk_stop = 1'b1;
   logic main_src_sel = 1'b0;
   logic periph_src_sel = 1'b0;
   logic cpu_src_sel = 1'b0;
   logic [2:0] cpu_div_sel = 3'h1;
   logic int_hs_stop = 1'b0;
   logic [2:0] osc_stab_sel = 3'h4;
   logic stop_exec = 1'b0;
   logic wake_req = 1'b0;
   logic xtal_clk_i = 1'b0;
   logic ext_clk_pin_i = 1'b0;
   logic int_hs_clk_i = 1'b0;
   logic sub_clk_i = 1'b0;
   logic crystal_in_pin_port, crystal_out_pin_port, xtal_osc_en, ext_clk_in_en;
   logic int_hs_osc_en, int_hs_stable, main_hs_active, sub_clk_active;
   logic [4:0] osc_stab_count_status;
   logic stop_mode, cpu_clk_out, periph_clk_out;
   logic [3:0] osc_div_r = 4'h0;
   int failures = 0;
   int checks_done = 0;
   int i, n, k;

   always #4 clk = ~clk;

   // oscillator stand-ins: crystal and internal only swing while enabled
   always @(posedge clk) begin
      osc_div_r <= osc_div_r + 4'h1;
      if (xtal_osc_en === 1'b1 && osc_div_r[0] == 1'b1) xtal_clk_i <= ~xtal_clk_i;
      if (osc_div_r[1:0] == 2'h3) ext_clk_pin_i <= ~ext_clk_pin_i;
      if (int_hs_osc_en === 1'b1 && osc_div_r[0] == 1'b0) int_hs_clk_i <= ~int_hs_clk_i;
      if (osc_div_r == 4'h7 || osc_div_r == 4'hF) sub_clk_i <= ~sub_clk_i;
   end

   mcd_top #(.OST_EXP(TAPS)) i_mcd_top (
      .clk(clk), .reset_n(reset_n), .ext_clk_sel(ext_clk_sel),
      .hs_pin_osc_sel(hs_pin_osc_sel), .hs_clk_stop(hs_clk_stop),
      .main_src_sel(main_src_sel), .periph_src_sel(periph_src_sel),
      .cpu_src_sel(cpu_src_sel), .cpu_div_sel(cpu_div_sel), .int_hs_stop(int_hs_stop),
      .osc_stab_sel(osc_stab_sel), .stop_exec(stop_exec), .wake_req(wake_req),
      .xtal_clk_i(xtal_clk_i), .ext_clk_pin_i(ext_clk_pin_i),
      .int_hs_clk_i(int_hs_clk_i), .sub_clk_i(sub_clk_i),
      .crystal_in_pin_port(crystal_in_pin_port),
      .crystal_out_pin_port(crystal_out_pin_port), .xtal_osc_en(xtal_osc_en),
      .ext_clk_in_en(ext_clk_in_en), .int_hs_osc_en(int_hs_osc_en),
      .int_hs_stable(int_hs_stable), .main_hs_active(main_hs_active),
      .sub_clk_active(sub_clk_active), .osc_stab_count_status(osc_stab_count_status),
      .stop_mode(stop_mode), .cpu_clk_out(cpu_clk_out), .periph_clk_out(periph_clk_out)
   );

   task end_of_test();
      $display("checks %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   // sample a little after the edge so the design's updates have landed
   task tick(input int cyc);
      repeat (cyc) @(posedge clk);
      #1;
   endtask

   // a bounded wait that ran dry ends the run
   task give_up(input string what, input int lim);
      if (i >= lim) begin
         failures++;
         $display("wrong value %s expected done seen timeout", what);
         end_of_test();
      end
   endtask

   // rising edges of the cpu or peripheral clock over a fixed span
   task count_rise(input bit use_periph, input int len, output int cnt);
      logic prev, cur;
      cnt = 0;
      prev = 1'b1;
      repeat (len) begin
         tick(1);
         cur = use_periph ? periph_clk_out : cpu_clk_out;
         if (cur === 1'b1 && prev === 1'b0) cnt++;
         prev = cur;
      end
   endtask

   // divider figure with one edge of slack for phase at the window ends
   task check_div(input int exp);
      count_rise(1'b0, 256, n);
      check("cpu clock edges", (n >= exp - 1 && n <= exp + 1), 1);
   endtask

   initial begin
      tick(5);
      check("first pin port", crystal_in_pin_port, 1);
      check("second pin port", crystal_out_pin_port, 1);
      check("crystal enable", xtal_osc_en, 0);
      check("ext input enable", ext_clk_in_en, 0);
      check("internal enable", int_hs_osc_en, 1);
      check("internal stable", int_hs_stable, 0);
      @(posedge clk);
      reset_n <= 1'b1;
      tick(3);
      check("stop mode", stop_mode, 0);
      check("cpu on internal", main_hs_active, 0);
      tick(100);
      check_div(32);
      for (i = 0; i < 400 && int_hs_stable !== 1'b1; i++) tick(1);
      give_up("internal stable", 400);
      check("internal stable", int_hs_stable, 1);
      // every divide code, then a refused one keeps the last ratio
      for (k = 0; k < 6; k++) begin
         @(posedge clk);
         cpu_div_sel <= (k == 5) ? 3'h5 : k[2:0];
         tick(100);
         check_div(k == 5 ? 4 : 64 >> k);
      end
      // crystal mode, start, settle, stop
      @(posedge clk);
      hs_pin_osc_sel <= 1'b1;
      hs_clk_stop <= 1'b0;
      tick(3);
      check("pin ports osc", {crystal_in_pin_port, crystal_out_pin_port}, 0);
      check("crystal enable", {xtal_osc_en, ext_clk_in_en}, 2);
      for (i = 0; i < 600 && osc_stab_count_status !== 5'h1F; i++) tick(1);
      give_up("settle count", 600);
      check("settle count", osc_stab_count_status, 5'h1F);
      check("cpu off hs", main_hs_active, 0);
      @(posedge clk);
      hs_clk_stop <= 1'b1;
      tick(2);
      check("crystal stopped", xtal_osc_en, 0);
      // external mode with the clock stopped first
      @(posedge clk);
      ext_clk_sel <= 1'b1;
      tick(3);
      check("pin ports ext", {crystal_in_pin_port, crystal_out_pin_port}, 2);
      check("ext still off", {xtal_osc_en, ext_clk_in_en}, 0);
      @(posedge clk);
      hs_clk_stop <= 1'b0;
      tick(2);
      check("ext input on", {xtal_osc_en, ext_clk_in_en}, 1);
      // main and peripheral select table; internal swings twice as fast
      for (k = 0; k < 4; k++) begin
         @(posedge clk);
         main_src_sel <= k[1];
         periph_src_sel <= k[0];
         tick(60);
         check("main on hs", main_hs_active, k == 3);
         count_rise(1'b1, 96, n);
         check("periph on internal", n > 18, k < 2);
      end
      // cpu now off the internal clock, so it may be stopped and restarted
      check("cpu off internal", main_hs_active, 1);
      @(posedge clk);
      int_hs_stop <= 1'b1;
      tick(3);
      check("internal stopped", {int_hs_osc_en, int_hs_stable}, 0);
      @(posedge clk);
      int_hs_stop <= 1'b0;
      tick(2);
      check("internal restarted", int_hs_osc_en, 1);
      for (i = 0; i < 400 && int_hs_stable !== 1'b1; i++) tick(1);
      give_up("internal stable again", 400);
      // subsystem clock to the cpu and back
      @(posedge clk);
      cpu_src_sel <= 1'b1;
      for (i = 0; i < 60 && sub_clk_active !== 1'b1; i++) tick(1);
      give_up("sub active", 60);
      @(posedge clk);
      cpu_src_sel <= 1'b0;
      // a slow divided clock may hold its high phase for a long while
      for (i = 0; i < 300 && sub_clk_active !== 1'b0; i++) tick(1);
      give_up("sub inactive", 300);
      check("status hs", {sub_clk_active, main_hs_active}, 1);
      // back to internal before stop, so wake needs no crystal wait
      @(posedge clk);
      main_src_sel <= 1'b0;
      periph_src_sel <= 1'b0;
      tick(60);
      check("status internal", {sub_clk_active, main_hs_active}, 0);
      check("internal stable before stop", int_hs_stable, 1);
      @(posedge clk);
      stop_exec <= 1'b1;
      @(posedge clk);
      stop_exec <= 1'b0;
      tick(1);
      check("in stop", stop_mode, 1);
      check("all sources off", {xtal_osc_en, ext_clk_in_en, int_hs_osc_en}, 0);
      count_rise(1'b0, 40, n);
      check("cpu gated in stop", n, 0);
      @(posedge clk);
      wake_req <= 1'b1;
      @(posedge clk);
      wake_req <= 1'b0;
      tick(3);
      check("left stop", stop_mode, 0);
      tick(10);
      @(posedge clk);
      hs_clk_stop <= 1'b1;
      tick(2);
      check("ext input off", ext_clk_in_en, 0);
      // crystal-fed cpu: wake holds in the settle wait for the shortest tap
      @(posedge clk);
      ext_clk_sel <= 1'b0;
      osc_stab_sel <= 3'h0;
      tick(2);
      @(posedge clk);
      hs_clk_stop <= 1'b0;
      main_src_sel <= 1'b1;
      periph_src_sel <= 1'b1;
      for (i = 0; i < 200 && main_hs_active !== 1'b1; i++) tick(1);
      give_up("main on crystal", 200);
      @(posedge clk);
      stop_exec <= 1'b1;
      @(posedge clk);
      stop_exec <= 1'b0;
      tick(3);
      check("crystal off in stop", xtal_osc_en, 0);
      @(posedge clk);
      wake_req <= 1'b1;
      @(posedge clk);
      wake_req <= 1'b0;
      tick(1);
      check("settle wait", stop_mode, 1);
      for (i = 0; i < 200 && stop_mode !== 1'b0; i++) tick(1);
      give_up("settle wait end", 200);
      check("crystal settled", osc_stab_count_status[0], 1);
      end_of_test();
   end

   // overall guard against a hang anywhere above
   initial begin
      repeat (100000) @(posedge clk);
      failures++;
      end_of_test();
   end
endmodule // test_mcd_top
